//--- hw/vmp_pkg.sv
/*
 * Shared constants and types for the video mode and palette control block.
 * Assumes a single 40 MHz clock domain and byte or word host I/O cycles.
 */
package vmp_pkg;
    // ------------------------------------------------------------------
    // Host port addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_SETUP_ID_LOW  = 16'h0100;
    localparam logic [15:0] ADDR_SETUP_ID_HIGH = 16'h0101;
    localparam logic [15:0] ADDR_SETUP_OPTION_SELECT     = 16'h0102;
    localparam logic [15:0] ADDR_PAL_MASK      = 16'h02ea;
    localparam logic [15:0] ADDR_PAL_RIDX      = 16'h02eb;
    localparam logic [15:0] ADDR_PAL_WIDX      = 16'h02ec;
    localparam logic [15:0] ADDR_PAL_DATA      = 16'h02ed;
    localparam logic [15:0] ADDR_ADV_FUNC      = 16'h4ae8;
    localparam logic [15:0] ALIAS_PAL_MASK     = 16'h03c6;
    localparam logic [15:0] ALIAS_PAL_RIDX     = 16'h03c7;
    localparam logic [15:0] ALIAS_PAL_WIDX     = 16'h03c8;
    localparam logic [15:0] ALIAS_PAL_DATA     = 16'h03c9;
    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int          ADV_MODE_BIT   = 0;
    localparam int          ADV_RES_BIT    = 2;
    localparam logic [15:0] ADV_WRITE_MASK = 16'h0007;
    localparam logic [15:0] ADV_RESET      = 16'h0000;
    localparam int          OPT_EN_BIT     = 0;
    localparam logic [7:0]  OPT_WRITE_MASK = 8'h01;
    localparam logic [7:0]  OPT_RESET      = 8'h01;
    localparam logic [7:0]  MASK_RESET     = 8'hff;
    localparam logic [7:0]  INDEX_RESET    = 8'h00;
    localparam logic [3:0]  PIN_RESET      = 4'hf;
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        VMP_CLK_25M18  = 3'b000,
        VMP_CLK_31M32  = 3'b100,
        VMP_CLK_44M90  = 3'b001,
        VMP_CLK_109M64 = 3'b101,
        VMP_CLK_136M71 = 3'b010,
        VMP_CLK_63M98  = 3'b011,
        VMP_CLK_74M16  = 3'b111
    } vmp_clk_sel_t;
    typedef enum logic [2:0] {
        VMP_MON_UNDEF      = 3'b000,
        VMP_MON_COLOR_1024 = 3'b001,
        VMP_MON_MONO_640   = 3'b010,
        VMP_MON_COLOR_640  = 3'b011,
        VMP_MON_OTHER      = 3'b100
    } vmp_monitor_t;
    typedef enum logic [1:0] {
        VMP_COMP_RED   = 2'b00,
        VMP_COMP_GREEN = 2'b01,
        VMP_COMP_BLUE  = 2'b10
    } vmp_comp_t;
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } vmp_host_req_t;
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } vmp_rgb_t;
endpackage

//--- hw/vmp_control.sv
/*
 * Mode register, monitor decode, oscillator select, palette ports with
 * auto-advancing indexes, and setup identification registers.
 * Assumes host strobes are synchronous to clk; monitor and setup pins are
 * asynchronous and pass a three-stage synchroniser.
 */
// Functional notes
// [RULE1] Decode monitor id codes; others undefined
// [RULE2] Board holds monitor id high during reset
// [RULE3] Drive documented oscillator select codes
// [RULE4] Board halves oscillator for 1280x1024 modes
// [RULE5] Board supplies separate system and pixel clocks
// [RULE6] Registers word wide; palette registers byte wide
// [RULE7] Unused and reserved bits read zero
// [RULE8] Index written once serves many accesses
// [RULE9] Write index advances after RGB triple
// [RULE10] Read index advances after RGB triple
// [RULE11] Pass-through aliases accept writes, refuse reads
// [RULE12] Mode bit 0 selects pass-through or graphics
// [RULE13] Software always sets mode extension bit
// [RULE14] Mode bit 2 selects resolution
// [RULE15] Setup registers answer only with select low
// [RULE16] Setup reads return identification low, high
// [RULE17] Setup option bit 0 enables all registers; code gates only mode and palette ports, setup registers still answer
// [RULE18] Indexes wrap, own component sequences
`timescale 1ns/1ps
module vmp_control (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire vmp_pkg::vmp_host_req_t host_req,
    output logic [15:0]                 host_rdata,
    output logic                        host_rvalid,
    input  wire logic [15:0]            boot_id,
    input  wire logic [2:0]             monitor_id_inputs,
    input  wire logic                   card_setup_select_n,
    input  wire logic [7:0]             pixel_index,
    output vmp_pkg::vmp_rgb_t           palette_rgb,
    output vmp_pkg::vmp_clk_sel_t       pixel_oscillator_select,
    output vmp_pkg::vmp_monitor_t       monitor_type,
    output logic                        graphics_mode,
    output logic                        hi_res_mode,
    output logic                        regs_enabled
);
    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic port_hit(input logic [15:0] a,
                                      input logic [15:0] main_addr,
                                      input logic [15:0] alias_addr,
                                      input logic        alias_ok);
        port_hit = (a == main_addr) || (alias_ok && (a == alias_addr));
    endfunction

    function automatic vmp_pkg::vmp_monitor_t decode_monitor(input logic [2:0] id);
        unique case (id)
            3'b010: decode_monitor = vmp_pkg::VMP_MON_COLOR_1024;
            3'b101: decode_monitor = vmp_pkg::VMP_MON_MONO_640;
            3'b110: decode_monitor = vmp_pkg::VMP_MON_COLOR_640;
            3'b111: decode_monitor = vmp_pkg::VMP_MON_OTHER;
            3'b000, 3'b001, 3'b011, 3'b100: decode_monitor = vmp_pkg::VMP_MON_UNDEF;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Pin synchroniser: bit 3 is the setup select, bits 2:0 monitor id
    // ------------------------------------------------------------------
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    logic [3:0] pin_s3_reg;
    logic [3:0] pin_reg;
    logic [3:0] pin_next;

    // A bit changes only once the second and third stages agree.
    always_comb begin
        pin_next = (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg))
                 | (pin_reg & (pin_s2_reg ^ pin_s3_reg));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1_reg <= vmp_pkg::PIN_RESET;
            pin_s2_reg <= vmp_pkg::PIN_RESET;
            pin_s3_reg <= vmp_pkg::PIN_RESET;
            pin_reg    <= vmp_pkg::PIN_RESET;
        end else begin
            pin_s1_reg <= {card_setup_select_n, monitor_id_inputs};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_reg    <= pin_next;
        end
    end

    logic setup_active;
    assign setup_active = ~pin_reg[3];

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [15:0]           adv_reg,  adv_next;
    logic [7:0]            opt_reg,  opt_next;
    logic [7:0]            mask_reg, mask_next;
    logic [7:0]            ridx_reg, ridx_next;
    logic [7:0]            widx_reg, widx_next;
    vmp_pkg::vmp_comp_t    rcomp_reg, rcomp_next;
    vmp_pkg::vmp_comp_t    wcomp_reg, wcomp_next;
    logic [7:0]            red_reg,  red_next;
    logic [7:0]            green_reg, green_next;
    logic [15:0]           id_reg,   id_next;
    logic                  id_loaded_reg, id_loaded_next;
    logic [15:0]           rdata_reg, rdata_next;
    logic                  rvalid_reg, rvalid_next;
    vmp_pkg::vmp_clk_sel_t clksel_reg, clksel_next;
    vmp_pkg::vmp_monitor_t mon_reg;
    vmp_pkg::vmp_rgb_t     rgb_reg;
    logic                  pal_we;
    vmp_pkg::vmp_rgb_t     pal_wentry;
    vmp_pkg::vmp_rgb_t     pal_mem [256];
    vmp_pkg::vmp_rgb_t     pal_rentry;
    logic                  pass_thru;
    logic                  en;
    logic [15:0]           a;

    assign pass_thru  = ~adv_reg[vmp_pkg::ADV_MODE_BIT];
    assign en         = opt_reg[vmp_pkg::OPT_EN_BIT];
    assign a          = host_req.addr;
    assign pal_rentry = pal_mem[ridx_reg];

    // ------------------------------------------------------------------
    // Host access
    // ------------------------------------------------------------------
    always_comb begin
        adv_next       = adv_reg;
        opt_next       = opt_reg;
        mask_next      = mask_reg;
        ridx_next      = ridx_reg;
        widx_next      = widx_reg;
        rcomp_next     = rcomp_reg;
        wcomp_next     = wcomp_reg;
        red_next       = red_reg;
        green_next     = green_reg;
        id_next        = id_reg;
        id_loaded_next = 1'b1;
        rdata_next     = 16'h0000;
        rvalid_next    = host_req.rd;
        pal_we         = 1'b0;
        pal_wentry     = '{red: red_reg, green: green_reg, blue: host_req.wdata[7:0]};
        // The identification value is caught in the first cycle after reset.
        if (!id_loaded_reg) begin
            id_next = boot_id;
        end
        if (setup_active) begin                                           // [RULE15]
            if (host_req.rd && a == vmp_pkg::ADDR_SETUP_ID_LOW) begin
                rdata_next = {8'h00, id_reg[7:0]};                       // [RULE16]
            end
            if (host_req.rd && a == vmp_pkg::ADDR_SETUP_ID_HIGH) begin
                rdata_next = {8'h00, id_reg[15:8]};                      // [RULE16]
            end
            if (host_req.rd && a == vmp_pkg::ADDR_SETUP_OPTION_SELECT) begin
                rdata_next = {8'h00, opt_reg};
            end
            if (host_req.wr && a == vmp_pkg::ADDR_SETUP_OPTION_SELECT) begin
                opt_next = host_req.wdata[7:0] & vmp_pkg::OPT_WRITE_MASK; // [RULE7]
            end
        end
        if (en && host_req.wr) begin                                      // [RULE17]
            if (a == vmp_pkg::ADDR_ADV_FUNC) begin
                adv_next = host_req.wdata & vmp_pkg::ADV_WRITE_MASK;     // [RULE12]
            end
            // Aliases take writes only in pass-through mode.
            if (port_hit(a, vmp_pkg::ADDR_PAL_MASK, vmp_pkg::ALIAS_PAL_MASK, pass_thru)) begin
                mask_next = host_req.wdata[7:0];                         // [RULE11]
            end
            if (port_hit(a, vmp_pkg::ADDR_PAL_RIDX, vmp_pkg::ALIAS_PAL_RIDX, pass_thru)) begin
                ridx_next  = host_req.wdata[7:0];                        // [RULE8]
                rcomp_next = vmp_pkg::VMP_COMP_RED;
            end
            if (port_hit(a, vmp_pkg::ADDR_PAL_WIDX, vmp_pkg::ALIAS_PAL_WIDX, pass_thru)) begin
                widx_next  = host_req.wdata[7:0];                        // [RULE8]
                wcomp_next = vmp_pkg::VMP_COMP_RED;
            end
            if (port_hit(a, vmp_pkg::ADDR_PAL_DATA, vmp_pkg::ALIAS_PAL_DATA, pass_thru)) begin
                unique case (wcomp_reg)                                  // [RULE18]
                    vmp_pkg::VMP_COMP_RED: begin
                        red_next   = host_req.wdata[7:0];
                        wcomp_next = vmp_pkg::VMP_COMP_GREEN;
                    end
                    vmp_pkg::VMP_COMP_GREEN: begin
                        green_next = host_req.wdata[7:0];
                        wcomp_next = vmp_pkg::VMP_COMP_BLUE;
                    end
                    default: begin
                        pal_we     = 1'b1;
                        widx_next  = widx_reg + 8'h01;                   // [RULE9]
                        wcomp_next = vmp_pkg::VMP_COMP_RED;
                    end
                endcase
            end
        end
        // Reads use the main ports only; alias reads return zero.
        if (en && host_req.rd) begin                                      // [RULE11]
            unique case (a)
                vmp_pkg::ADDR_PAL_MASK: rdata_next = {8'h00, mask_reg};  // [RULE6]
                vmp_pkg::ADDR_PAL_RIDX: rdata_next = {8'h00, ridx_reg};
                vmp_pkg::ADDR_PAL_WIDX: rdata_next = {8'h00, widx_reg};
                vmp_pkg::ADDR_PAL_DATA: begin
                    unique case (rcomp_reg)                              // [RULE18]
                        vmp_pkg::VMP_COMP_RED: begin
                            rdata_next = {8'h00, pal_rentry.red};
                            rcomp_next = vmp_pkg::VMP_COMP_GREEN;
                        end
                        vmp_pkg::VMP_COMP_GREEN: begin
                            rdata_next = {8'h00, pal_rentry.green};
                            rcomp_next = vmp_pkg::VMP_COMP_BLUE;
                        end
                        default: begin
                            rdata_next = {8'h00, pal_rentry.blue};
                            ridx_next  = ridx_reg + 8'h01;               // [RULE10]
                            rcomp_next = vmp_pkg::VMP_COMP_RED;
                        end
                    endcase
                end
                default: ;
            endcase
        end
        // Pass-through and the low resolution share the 25.18 MHz source.
        if (adv_reg[vmp_pkg::ADV_MODE_BIT] && adv_reg[vmp_pkg::ADV_RES_BIT]) begin
            clksel_next = vmp_pkg::VMP_CLK_44M90;                        // [RULE14]
        end else begin
            clksel_next = vmp_pkg::VMP_CLK_25M18;                        // [RULE3]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            adv_reg       <= vmp_pkg::ADV_RESET;
            opt_reg       <= vmp_pkg::OPT_RESET;
            mask_reg      <= vmp_pkg::MASK_RESET;
            ridx_reg      <= vmp_pkg::INDEX_RESET;
            widx_reg      <= vmp_pkg::INDEX_RESET;
            rcomp_reg     <= vmp_pkg::VMP_COMP_RED;
            wcomp_reg     <= vmp_pkg::VMP_COMP_RED;
            red_reg       <= 8'h00;
            green_reg     <= 8'h00;
            id_reg        <= 16'h0000;
            id_loaded_reg <= 1'b0;
            rdata_reg     <= 16'h0000;
            rvalid_reg    <= 1'b0;
            clksel_reg    <= vmp_pkg::VMP_CLK_25M18;
            mon_reg       <= vmp_pkg::VMP_MON_OTHER;
            rgb_reg       <= '0;
        end else begin
            adv_reg       <= adv_next;
            opt_reg       <= opt_next;
            mask_reg      <= mask_next;
            ridx_reg      <= ridx_next;
            widx_reg      <= widx_next;
            rcomp_reg     <= rcomp_next;
            wcomp_reg     <= wcomp_next;
            red_reg       <= red_next;
            green_reg     <= green_next;
            id_reg        <= id_next;
            id_loaded_reg <= id_loaded_next;
            rdata_reg     <= rdata_next;
            rvalid_reg    <= rvalid_next;
            clksel_reg    <= clksel_next;
            mon_reg       <= decode_monitor(pin_reg[2:0]);               // [RULE1]
            rgb_reg       <= pal_mem[pixel_index & mask_reg];
        end
    end

    // The palette array has no reset; entries are undefined until loaded.
    always_ff @(posedge clk) begin
        if (pal_we) begin
            pal_mem[widx_reg] <= pal_wentry;
        end
    end

    assign host_rdata              = rdata_reg;
    assign host_rvalid             = rvalid_reg;
    assign palette_rgb             = rgb_reg;
    assign pixel_oscillator_select = clksel_reg;
    assign monitor_type            = mon_reg;
    assign graphics_mode           = adv_reg[vmp_pkg::ADV_MODE_BIT];
    assign hi_res_mode             = adv_reg[vmp_pkg::ADV_RES_BIT];
    assign regs_enabled            = en;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_rd_answer_next: assert property (host_req.rd |=> host_rvalid) // [RULE6]
        else $error("read not answered next cycle");
    a_reserved_zero: assert property (adv_reg[15:3] == 13'h0000) // [RULE7]
        else $error("reserved mode bits nonzero");
    a_hires_clock: assert property (en && host_req.wr && a == vmp_pkg::ADDR_ADV_FUNC // [RULE14]
        && (host_req.wdata & 16'h0005) == 16'h0005
        |-> ##2 pixel_oscillator_select == vmp_pkg::VMP_CLK_44M90)
        else $error("high resolution clock not selected");
    a_widx_step: assert property (en && host_req.wr && a == vmp_pkg::ADDR_PAL_DATA // [RULE9]
        && wcomp_reg == vmp_pkg::VMP_COMP_BLUE |=> widx_reg == $past(widx_reg) + 8'h01)
        else $error("write index did not advance");
    a_ridx_step: assert property (en && host_req.rd && a == vmp_pkg::ADDR_PAL_DATA // [RULE10]
        && rcomp_reg == vmp_pkg::VMP_COMP_BLUE |=> ridx_reg == $past(ridx_reg) + 8'h01)
        else $error("read index did not advance");
    a_alias_no_read: assert property (host_req.rd && a == vmp_pkg::ALIAS_PAL_DATA // [RULE11]
        |=> host_rdata == 16'h0000 && $stable(ridx_reg))
        else $error("alias read answered");
    a_setup_gated: assert property (host_req.rd && !setup_active // [RULE15]
        && a == vmp_pkg::ADDR_SETUP_ID_LOW |=> host_rdata == 16'h0000)
        else $error("setup register answered outside setup");
    a_setup_id_low: assert property (host_req.rd && setup_active // [RULE16]
        && a == vmp_pkg::ADDR_SETUP_ID_LOW |=> host_rdata == {8'h00, id_reg[7:0]})
        else $error("setup id low byte wrong");
    a_disabled_hold: assert property (!en && host_req.wr // [RULE17]
        && a == vmp_pkg::ADDR_PAL_MASK |=> $stable(mask_reg))
        else $error("disabled register was written");
    a_monitor_code: assert property (pin_reg[2:0] == 3'b010 // [RULE1]
        |=> monitor_type == vmp_pkg::VMP_MON_COLOR_1024)
        else $error("monitor code misdecoded");
    a_index_restart: assert property (en && host_req.wr && a == vmp_pkg::ADDR_PAL_WIDX // [RULE8]
        |=> wcomp_reg == vmp_pkg::VMP_COMP_RED)
        else $error("component sequence not restarted");

    c_entry_written: cover property (pal_we);
    c_entry_read: cover property (host_req.rd && a == vmp_pkg::ADDR_PAL_DATA
        && rcomp_reg == vmp_pkg::VMP_COMP_BLUE);
    c_setup_read: cover property (host_req.rd && setup_active
        && a == vmp_pkg::ADDR_SETUP_ID_HIGH);
endmodule

//--- sim/vmp_host_model.sv
/*
 * Host bus model: issues single-cycle register writes and reads.
 * Assumes the block takes a request on a rising edge with wr or rd high.
 */
`timescale 1ns/1ps
module vmp_host_model (
    input  wire logic              clk,
    output vmp_pkg::vmp_host_req_t host_req,
    input  wire logic [15:0]       host_rdata,
    input  wire logic              host_rvalid,
    output logic                   hung
);
    initial begin
        host_req = '0;
        hung     = 1'b0;
    end
    // Released address and data are inverted so stale values never look valid.
    task automatic write_reg(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        host_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clk);
        host_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
    task automatic read_reg(input logic [15:0] a, output logic [15:0] d);
        int n;
        @(negedge clk);
        host_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
        @(negedge clk);
        host_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 16'hffff};
        n = 0;
        while (host_rvalid !== 1'b1 && n < 3) begin
            @(negedge clk);
            n++;
        end
        d = host_rdata;
        if (n == 3) hung = 1'b1;
    endtask
endmodule

//--- sim/video_mode_palette_control_tb.sv
/*
 * Self-checking bench for the mode, palette and setup register block.
 * Assumes the host model in vmp_host_model and a 40 MHz clock.
 */
`timescale 1ns/1ps
module video_mode_palette_control_tb;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    vmp_pkg::vmp_host_req_t host_req;
    logic [15:0]            host_rdata;
    logic                   host_rvalid;
    logic                   hung;
    logic [2:0]             mon = 3'b111;
    logic                   sel_n = 1'b1;
    logic [7:0]             pixel_index = 8'h00;
    vmp_pkg::vmp_rgb_t      palette_rgb;
    vmp_pkg::vmp_clk_sel_t  osc;
    vmp_pkg::vmp_monitor_t  mon_type;
    logic                   graphics_mode;
    logic                   hi_res_mode;
    logic                   regs_enabled;
    logic [15:0]            rd_data;
    int                     error_cnt = 0;
    int                     n_checks = 0;
    // Identification value is arbitrary.
    localparam logic [15:0] BOOT_ID = 16'h5a3c;

    // The block runs from one clock; the pixel clock stays on the board side.
    always #12.5 clk = ~clk;

    vmp_host_model host (.clk(clk), .host_req(host_req), .host_rdata(host_rdata),
                         .host_rvalid(host_rvalid), .hung(hung));
    vmp_control dut (.clk(clk), .rst(rst), .host_req(host_req), .host_rdata(host_rdata),
                     .host_rvalid(host_rvalid), .boot_id(BOOT_ID),
                     .monitor_id_inputs(mon), .card_setup_select_n(sel_n),
                     .pixel_index(pixel_index), .palette_rgb(palette_rgb),
                     .pixel_oscillator_select(osc), .monitor_type(mon_type),
                     .graphics_mode(graphics_mode), .hi_res_mode(hi_res_mode),
                     .regs_enabled(regs_enabled));

    task automatic give_verdict();
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string what, input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp);
        host.read_reg(a, rd_data);
        if (hung) begin
            error_cnt++;
            give_verdict();
        end else begin
            check(what, {8'h00, rd_data}, {8'h00, exp});
        end
    endtask
    function automatic logic [7:0] pb(input int i);
        return 8'(8'h21 * i + 8'h05);
    endfunction
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        check("graphics", 24'(graphics_mode), 24'h000000);
        check("hires", 24'(hi_res_mode), 24'h000000);
        check("enabled", 24'(regs_enabled), 24'h000001);
        check("osc", 24'(osc), 24'(vmp_pkg::VMP_CLK_25M18));
        rd_chk("mask", vmp_pkg::ADDR_PAL_MASK, 16'h00ff);
        rd_chk("unmapped", 16'h0200, 16'h0000);
    endtask
    task automatic t_mode();
        host.write_reg(vmp_pkg::ADDR_ADV_FUNC, 16'h0007);
        wait_cyc(2);
        check("graphics", 24'(graphics_mode), 24'h000001);
        check("hires", 24'(hi_res_mode), 24'h000001);
        // The design never picks a code that the board would have to halve.
        check("osc hi", 24'(osc), 24'(vmp_pkg::VMP_CLK_44M90));
        rd_chk("mode wo", vmp_pkg::ADDR_ADV_FUNC, 16'h0000);
        host.write_reg(vmp_pkg::ADDR_ADV_FUNC, 16'h0003);
        wait_cyc(2);
        check("osc lo", 24'(osc), 24'(vmp_pkg::VMP_CLK_25M18));
    endtask
    task automatic t_palette();
        host.write_reg(vmp_pkg::ADDR_PAL_WIDX, 16'h00ff);
        for (int i = 0; i < 6; i++) begin
            host.write_reg(vmp_pkg::ADDR_PAL_DATA, {8'h00, pb(i)});
        end
        pixel_index = 8'hff;
        wait_cyc(2);
        check("rgb ff", palette_rgb, {pb(0), pb(1), pb(2)});
        host.write_reg(vmp_pkg::ADDR_PAL_MASK, 16'h0000);
        wait_cyc(2);
        check("rgb masked", palette_rgb, {pb(3), pb(4), pb(5)});
        host.write_reg(vmp_pkg::ADDR_PAL_MASK, 16'h00ff);
        host.write_reg(vmp_pkg::ADDR_PAL_RIDX, 16'h00ff);
        for (int i = 0; i < 6; i++) begin
            rd_chk("data", vmp_pkg::ADDR_PAL_DATA, {8'h00, pb(i)});
        end
    endtask
    task automatic t_alias();
        host.write_reg(vmp_pkg::ALIAS_PAL_MASK, 16'h0000);
        rd_chk("alias gfx", vmp_pkg::ADDR_PAL_MASK, 16'h00ff);
        host.write_reg(vmp_pkg::ADDR_ADV_FUNC, 16'h0002);
        host.write_reg(vmp_pkg::ALIAS_PAL_MASK, 16'h003c);
        rd_chk("alias wr", vmp_pkg::ADDR_PAL_MASK, 16'h003c);
        rd_chk("alias rd", vmp_pkg::ALIAS_PAL_MASK, 16'h0000);
        rd_chk("alias data", vmp_pkg::ALIAS_PAL_DATA, 16'h0000);
        host.write_reg(vmp_pkg::ADDR_PAL_MASK, 16'h00ff);
    endtask
    task automatic t_monitor();
        logic [2:0] exp [8] = '{3'b000, 3'b000, 3'b001, 3'b000, 3'b000, 3'b010, 3'b011, 3'b100};
        for (int c = 0; c < 8; c++) begin
            mon = 3'(c);
            wait_cyc(8);
            check("monitor", 24'(mon_type), 24'(exp[c]));
        end
        mon = 3'b111;
    endtask
    task automatic t_setup();
        rd_chk("id off", vmp_pkg::ADDR_SETUP_ID_LOW, 16'h0000);
        sel_n = 1'b0;
        wait_cyc(6);
        rd_chk("id low", vmp_pkg::ADDR_SETUP_ID_LOW, {8'h00, BOOT_ID[7:0]});
        rd_chk("id high", vmp_pkg::ADDR_SETUP_ID_HIGH, {8'h00, BOOT_ID[15:8]});
        host.write_reg(vmp_pkg::ADDR_SETUP_OPTION_SELECT, 16'h00fe);
        wait_cyc(1);
        check("disabled", 24'(regs_enabled), 24'h000000);
        rd_chk("mask off", vmp_pkg::ADDR_PAL_MASK, 16'h0000);
        rd_chk("opt", vmp_pkg::ADDR_SETUP_OPTION_SELECT, 16'h0000);
        // A write while disabled must be dropped.
        host.write_reg(vmp_pkg::ADDR_PAL_MASK, 16'h0012);
        host.write_reg(vmp_pkg::ADDR_SETUP_OPTION_SELECT, 16'h0001);
        wait_cyc(1);
        check("enabled", 24'(regs_enabled), 24'h000001);
        rd_chk("mask kept", vmp_pkg::ADDR_PAL_MASK, 16'h00ff);
        sel_n = 1'b1;
        wait_cyc(6);
        host.write_reg(vmp_pkg::ADDR_SETUP_OPTION_SELECT, 16'h0000);
        wait_cyc(1);
        check("opt locked", 24'(regs_enabled), 24'h000001);
    endtask

    initial begin
        // Monitor pins stay high through reset, as the board holds them.
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        wait_cyc(2);
        t_reset();
        t_mode();
        t_palette();
        t_alias();
        t_monitor();
        t_setup();
        give_verdict();
    end
endmodule
